// ---- design/tbd_core.sv ----
// How it works
// - one cycle, two when skipping or branching
// - four oscillator periods per instruction cycle
// - destination bit picks accumulator or file
// - byte format: opcode, destination, file address
// - bit format: opcode, bit number, file
// - literal format: opcode and eight-bit literal
// - jump carries nine-bit target literal
// - program counter writes clear bit eight
// - port read-modify-write uses pin levels
// - direction load copies accumulator to latches
// - timer writes clear assigned prescaler
// - increment/decrement skip on zero, no flags
// - bit set/clear/test, flags untouched
// - byte logic ops update only zero
// - rotates through carry, carry only
// - literal logic ops into accumulator, zero
// - return loads literal, pops, two cycles
// - standby entry updates timeout and powerdown
// - option load copies accumulator, no flags
// - move file sets zero flag
// - load literal into accumulator, no flags
`timescale 1ns/1ps
module tbd_core (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // program memory
  output logic [tbd_pkg::TBD_PC_W-1:0] progAddr,
  input wire logic [11:0] instrWord,
  // file register memory
  output logic [4:0] fileAddr,
  input wire logic [7:0] fileRdData,
  output logic fileWrEn,
  output logic [7:0] fileWrData,
  // port pins and peripherals
  input wire logic [tbd_pkg::TBD_PORT_W-1:0] portPins,
  output logic [tbd_pkg::TBD_PORT_W-1:0] portDir,
  output logic [7:0] optionOut,
  output logic prescalerClr,
  output logic wdtClr,
  output logic standby,
  input wire logic wakeReq,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData
);
  import tbd_pkg::*;

  tbd_state_t state_r;
  logic [1:0] qPhase_r;
  logic [TBD_PC_W-1:0] pc_r;
  logic [11:0] instr_r;
  logic [7:0] acc_r;
  logic [7:0] status_r;
  logic [7:0] option_r;
  logic [5:0] dir_r;
  logic [7:0] ctrl_r;
  logic [TBD_PC_W-1:0] stack_r [TBD_STACK_DEPTH];
  logic [4:0] fileAddr_r;
  logic fileWrEn_r;
  logic [7:0] fileWrData_r;
  logic prescalerClr_r;
  logic wdtClr_r;
  logic standby_r;
  logic [7:0] regRdData_r;
  logic [TBD_PORT_W-1:0] pinS1_r, pinS2_r, pinS3_r, pinFilt_r;
  logic wakeS1_r, wakeS2_r, wakeS3_r, wakeFilt_r;

  logic running;
  logic execNow;
  logic [4:0] fAddr;
  logic destF;
  logic [2:0] bitNum;
  logic [7:0] lit;
  logic [7:0] fileVal;
  logic [8:0] sum9;
  logic [8:0] diff9;
  logic [4:0] sumNib;
  logic [4:0] diffNib;
  logic [7:0] res;
  logic wrAcc, wrFile, updZ, updC, updDC, newC, newDC;
  logic jump, skip, push, pop, optLd, dirLd, sleepGo, wdtGo;
  logic [TBD_PC_W-1:0] jumpAddr;
  logic [7:0] status_nxt;
  logic [TBD_PC_W-1:0] pcInc;

  // mask of the bit named by the bit field
  function automatic logic [7:0] bitMask(input logic [2:0] n);
    bitMask = 8'h01 << n;
  endfunction : bitMask

  // four-phase cycle
  // the phase counter freezes while halted so a resume restarts cleanly
  assign running = ctrl_r[TBD_CTRL_RUN] && (state_r != TBD_STANDBY);
  assign execNow = running && (qPhase_r == TBD_Q_EXEC);
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      qPhase_r <= 2'h0;
    end else if (running) begin
      qPhase_r <= (qPhase_r == TBD_Q_LAST) ? 2'h0 : qPhase_r + 2'h1;
    end
  end

  // pin synchroniser
  // three stages; a change is taken only when the last two agree
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pinS1_r <= '0;
      pinS2_r <= '0;
      pinS3_r <= '0;
      pinFilt_r <= '0;
      wakeS1_r <= 1'b0;
      wakeS2_r <= 1'b0;
      wakeS3_r <= 1'b0;
      wakeFilt_r <= 1'b0;
    end else begin
      pinS1_r <= portPins;
      pinS2_r <= pinS1_r;
      pinS3_r <= pinS2_r;
      if (pinS2_r == pinS3_r) pinFilt_r <= pinS3_r;
      wakeS1_r <= wakeReq;
      wakeS2_r <= wakeS1_r;
      wakeS3_r <= wakeS2_r;
      if (wakeS2_r == wakeS3_r) wakeFilt_r <= wakeS3_r;
    end
  end

  // fetch and file address
  // memory has two clocks to answer before the execute phase
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      instr_r <= 12'h000;
      fileAddr_r <= 5'h00;
    end else if (running && qPhase_r == TBD_Q_CAPTURE) begin
      instr_r <= instrWord;
      fileAddr_r <= instrWord[4:0];
    end
  end

  assign fAddr = instr_r[4:0];
  assign destF = instr_r[5];
  assign bitNum = instr_r[7:5];
  assign lit = instr_r[7:0];
  assign pcInc = pc_r + 9'h001;

  // operand source; port reads come from pins
  always_comb begin
    if (fAddr == TBD_FA_STATUS) begin
      fileVal = status_r;
    end else if (fAddr == TBD_FA_PORT) begin
      fileVal = {2'b00, pinFilt_r};
    end else if (fAddr == TBD_FA_PCL) begin
      // pc low lives here, read as the next word so adds make table jumps
      fileVal = pcInc[7:0];
    end else begin
      fileVal = fileRdData;
    end
  end

  assign sum9 = {1'b0, fileVal} + {1'b0, acc_r};
  assign diff9 = {1'b0, fileVal} + {1'b0, ~acc_r} + 9'h001;
  assign sumNib = {1'b0, fileVal[3:0]} + {1'b0, acc_r[3:0]};
  assign diffNib = {1'b0, fileVal[3:0]} + {1'b0, ~acc_r[3:0]} + 5'h01;

  // instruction execution
  always_comb begin
    res = 8'h00;
    wrAcc = 1'b0;
    wrFile = 1'b0;
    updZ = 1'b0;
    updC = 1'b0;
    updDC = 1'b0;
    newC = status_r[TBD_ST_C];
    newDC = status_r[TBD_ST_DC];
    jump = 1'b0;
    jumpAddr = pcInc;
    skip = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    optLd = 1'b0;
    dirLd = 1'b0;
    sleepGo = 1'b0;
    wdtGo = 1'b0;
    if (instr_r[11:10] == 2'b00) begin
      wrAcc = !destF;
      wrFile = destF;
      case (instr_r[11:6])
        OP_MISC: begin
          wrAcc = 1'b0;
          res = acc_r;
          if (!destF) begin
            case (fAddr)
              MISC_OPTION: optLd = 1'b1;
              MISC_STANDBY: sleepGo = 1'b1;
              MISC_WDT_CLR: wdtGo = 1'b1;
              MISC_DIR_LOAD: dirLd = 1'b1;
              default: ;
            endcase
          end
        end
        OP_CLEAR: begin
          res = 8'h00;
          updZ = 1'b1;
        end
        OP_SUB: begin
          res = diff9[7:0];
          newC = diff9[8];
          newDC = diffNib[4];
          {updZ, updC, updDC} = 3'b111;
        end
        OP_DEC: begin
          res = fileVal - 8'h01;
          updZ = 1'b1;
        end
        OP_OR: begin
          res = fileVal | acc_r;
          updZ = 1'b1;
        end
        OP_AND: begin
          res = fileVal & acc_r;
          updZ = 1'b1;
        end
        OP_XOR: begin
          res = fileVal ^ acc_r;
          updZ = 1'b1;
        end
        OP_ADD: begin
          res = sum9[7:0];
          newC = sum9[8];
          newDC = sumNib[4];
          {updZ, updC, updDC} = 3'b111;
        end
        OP_MOVE: begin
          res = fileVal;
          updZ = 1'b1;
        end
        OP_COMP: begin
          res = ~fileVal;
          updZ = 1'b1;
        end
        OP_INC: begin
          res = fileVal + 8'h01;
          updZ = 1'b1;
        end
        OP_DEC_SKIP: begin
          res = fileVal - 8'h01;
          skip = (res == 8'h00);
        end
        OP_ROT_RIGHT: begin
          res = {status_r[TBD_ST_C], fileVal[7:1]};
          newC = fileVal[0];
          updC = 1'b1;
        end
        OP_ROT_LEFT: begin
          res = {fileVal[6:0], status_r[TBD_ST_C]};
          newC = fileVal[7];
          updC = 1'b1;
        end
        OP_SWAP: res = {fileVal[3:0], fileVal[7:4]};
        OP_INC_SKIP: begin
          res = fileVal + 8'h01;
          skip = (res == 8'h00);
        end
        default: ;
      endcase
      // the misc group with d=1 writes the accumulator to the file
      if (instr_r[11:6] == OP_MISC && destF) res = acc_r;
    end else if (instr_r[11:10] == 2'b01) begin
      case (instr_r[11:8])
        OP_BIT_CLR: begin
          res = fileVal & ~bitMask(bitNum);
          wrFile = 1'b1;
        end
        OP_BIT_SET: begin
          res = fileVal | bitMask(bitNum);
          wrFile = 1'b1;
        end
        OP_TEST_CLR: skip = !fileVal[bitNum];
        OP_TEST_SET: skip = fileVal[bitNum];
        default: ;
      endcase
    end else if (instr_r[11:9] == OP_JUMP) begin
      jump = 1'b1;
      jumpAddr = instr_r[8:0];
    end else begin
      case (instr_r[11:8])
        OP_RETURN: begin
          res = lit;
          wrAcc = 1'b1;
          jump = 1'b1;
          pop = 1'b1;
          jumpAddr = stack_r[0];
        end
        OP_CALL: begin
          jump = 1'b1;
          push = 1'b1;
          jumpAddr = {1'b0, lit};
        end
        OP_LOAD_LIT: begin
          res = lit;
          wrAcc = 1'b1;
        end
        OP_OR_LIT: begin
          res = lit | acc_r;
          wrAcc = 1'b1;
          updZ = 1'b1;
        end
        OP_AND_LIT: begin
          res = lit & acc_r;
          wrAcc = 1'b1;
          updZ = 1'b1;
        end
        default: begin
          res = lit ^ acc_r;
          wrAcc = 1'b1;
          updZ = 1'b1;
        end
      endcase
    end
    // file write to pc clears bit eight
    if (wrFile && fAddr == TBD_FA_PCL) begin
      jump = 1'b1;
      jumpAddr = {1'b0, res};
    end
  end

  // next status: software-writable bits first, flags on top
  always_comb begin
    status_nxt = status_r;
    if (wrFile && fAddr == TBD_FA_STATUS) begin
      status_nxt = (status_r & ~TBD_ST_SW_MASK) | (res & TBD_ST_SW_MASK);
    end
    if (updZ) status_nxt[TBD_ST_Z] = (res == 8'h00);
    if (updC) status_nxt[TBD_ST_C] = newC;
    if (updDC) status_nxt[TBD_ST_DC] = newDC;
    if (sleepGo) begin
      status_nxt[TBD_ST_TO] = 1'b1;
      status_nxt[TBD_ST_PD] = 1'b0;
    end
    if (wdtGo) begin
      status_nxt[TBD_ST_TO] = 1'b1;
      status_nxt[TBD_ST_PD] = 1'b1;
    end
  end

  // sequencer, second cycle as a bubble
  // the fetched word after a branch or skip is simply not executed
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_r <= TBD_RUN;
      standby_r <= 1'b0;
    end else if (state_r == TBD_STANDBY) begin
      if (wakeFilt_r) begin
        state_r <= TBD_RUN;
        standby_r <= 1'b0;
      end
    end else if (execNow) begin
      case (state_r)
        TBD_RUN: begin
          if (sleepGo) begin
            state_r <= TBD_STANDBY;
            standby_r <= 1'b1;
          end else if (jump || skip) begin
            state_r <= TBD_BUBBLE;
          end
        end
        default: state_r <= TBD_RUN;
      endcase
    end
  end

  // program counter and stack
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pc_r <= TBD_PC_RST;
      for (int i = 0; i < TBD_STACK_DEPTH; i++) stack_r[i] <= TBD_PC_RST;
    end else if (execNow && state_r == TBD_RUN) begin
      pc_r <= jump ? jumpAddr : (skip ? pc_r + 9'h002 : pcInc);
      if (push) begin
        stack_r[0] <= pcInc;
        for (int i = 1; i < TBD_STACK_DEPTH; i++) stack_r[i] <= stack_r[i-1];
      end else if (pop) begin
        for (int i = 0; i < TBD_STACK_DEPTH - 1; i++) begin
          stack_r[i] <= stack_r[i+1];
        end
      end
    end
  end

  // accumulator, status, option and direction latches
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      acc_r <= 8'h00;
      status_r <= TBD_STATUS_RST;
      option_r <= TBD_OPTION_RST;
      dir_r <= TBD_DIR_RST;
    end else if (execNow && state_r == TBD_RUN) begin
      if (wrAcc) acc_r <= res;
      status_r <= status_nxt;
      if (optLd) option_r <= acc_r;
      if (dirLd) dir_r <= acc_r[5:0];
    end
  end

  // file write and peripheral pulses, one clock each
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      fileWrEn_r <= 1'b0;
      fileWrData_r <= 8'h00;
      prescalerClr_r <= 1'b0;
      wdtClr_r <= 1'b0;
    end else begin
      fileWrEn_r <= 1'b0;
      prescalerClr_r <= 1'b0;
      wdtClr_r <= 1'b0;
      if (execNow && state_r == TBD_RUN) begin
        if (wrFile && fAddr != TBD_FA_STATUS && fAddr != TBD_FA_PCL) begin
          fileWrEn_r <= 1'b1;
          fileWrData_r <= res;
        end
        prescalerClr_r <= wrFile && fAddr == TBD_FA_TIMER &&
                          !option_r[TBD_OPT_PSA];
        wdtClr_r <= wdtGo || sleepGo;
      end
    end
  end

  // register port: only control is writable, others show core state
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl_r <= TBD_CTRL_RST;
      regRdData_r <= 8'h00;
    end else begin
      if (regWr && regAddr == TBD_REG_CTRL) ctrl_r <= regWrData;
      regRdData_r <= 8'h00;
      if (regRd) begin
        if (regAddr == TBD_REG_CTRL) regRdData_r <= ctrl_r;
        else if (regAddr == TBD_REG_ACC) regRdData_r <= acc_r;
        else if (regAddr == TBD_REG_STATUS) regRdData_r <= status_r;
        else if (regAddr == TBD_REG_OPTION) regRdData_r <= option_r;
        else if (regAddr == TBD_REG_PCLO) regRdData_r <= pc_r[7:0];
        else if (regAddr == TBD_REG_PCHI) regRdData_r <= {7'h00, pc_r[8]};
        else if (regAddr == TBD_REG_DIR) regRdData_r <= {2'b00, dir_r};
      end
    end
  end

  // outputs straight from flops
  assign progAddr = pc_r;
  assign fileAddr = fileAddr_r;
  assign fileWrEn = fileWrEn_r;
  assign fileWrData = fileWrData_r;
  assign portDir = dir_r;
  assign optionOut = option_r;
  assign prescalerClr = prescalerClr_r;
  assign wdtClr = wdtClr_r;
  assign standby = standby_r;
  assign regRdData = regRdData_r;
endmodule : tbd_core

// ---- design/tbd_pkg.sv ----
package tbd_pkg;
  // widths of the core
  localparam int TBD_PC_W = 9;
  localparam int TBD_STACK_DEPTH = 2;
  localparam int TBD_PORT_W = 6;
  // instruction cycle: four oscillator periods, numbered 0 to 3
  localparam logic [1:0] TBD_Q_LAST = 2'h3;
  localparam logic [1:0] TBD_Q_CAPTURE = 2'h1;
  localparam logic [1:0] TBD_Q_EXEC = 2'h3;
  // file addresses handled inside the core or watched by it
  localparam logic [4:0] TBD_FA_TIMER = 5'h01;
  localparam logic [4:0] TBD_FA_PCL = 5'h02;
  localparam logic [4:0] TBD_FA_STATUS = 5'h03;
  localparam logic [4:0] TBD_FA_PORT = 5'h06;
  // status field positions
  localparam int TBD_ST_C = 0;
  localparam int TBD_ST_DC = 1;
  localparam int TBD_ST_Z = 2;
  localparam int TBD_ST_PD = 3;
  localparam int TBD_ST_TO = 4;
  localparam logic [7:0] TBD_ST_SW_MASK = 8'h27;
  // option field: prescaler goes to the watchdog when set
  localparam int TBD_OPT_PSA = 3;
  // reset values
  localparam logic [7:0] TBD_STATUS_RST = 8'h18;
  localparam logic [7:0] TBD_OPTION_RST = 8'hff;
  localparam logic [5:0] TBD_DIR_RST = 6'h3f;
  localparam logic [8:0] TBD_PC_RST = 9'h000;
  localparam logic [7:0] TBD_CTRL_RST = 8'h01;
  localparam int TBD_CTRL_RUN = 0;
  // register port offsets
  localparam logic [3:0] TBD_REG_CTRL = 4'h0;
  localparam logic [3:0] TBD_REG_ACC = 4'h1;
  localparam logic [3:0] TBD_REG_STATUS = 4'h2;
  localparam logic [3:0] TBD_REG_OPTION = 4'h3;
  localparam logic [3:0] TBD_REG_PCLO = 4'h4;
  localparam logic [3:0] TBD_REG_PCHI = 4'h5;
  localparam logic [3:0] TBD_REG_DIR = 4'h6;
  // byte-oriented opcodes, bits 11 to 6
  localparam logic [5:0] OP_MISC = 6'h00;
  localparam logic [5:0] OP_CLEAR = 6'h01;
  localparam logic [5:0] OP_SUB = 6'h02;
  localparam logic [5:0] OP_DEC = 6'h03;
  localparam logic [5:0] OP_OR = 6'h04;
  localparam logic [5:0] OP_AND = 6'h05;
  localparam logic [5:0] OP_XOR = 6'h06;
  localparam logic [5:0] OP_ADD = 6'h07;
  localparam logic [5:0] OP_MOVE = 6'h08;
  localparam logic [5:0] OP_COMP = 6'h09;
  localparam logic [5:0] OP_INC = 6'h0a;
  localparam logic [5:0] OP_DEC_SKIP = 6'h0b;
  localparam logic [5:0] OP_ROT_RIGHT = 6'h0c;
  localparam logic [5:0] OP_ROT_LEFT = 6'h0d;
  localparam logic [5:0] OP_SWAP = 6'h0e;
  localparam logic [5:0] OP_INC_SKIP = 6'h0f;
  // low fields of the misc group with bit 5 clear
  localparam logic [4:0] MISC_NOP = 5'h00;
  localparam logic [4:0] MISC_OPTION = 5'h02;
  localparam logic [4:0] MISC_STANDBY = 5'h03;
  localparam logic [4:0] MISC_WDT_CLR = 5'h04;
  localparam logic [4:0] MISC_DIR_LOAD = 5'h06;
  // bit-oriented opcodes, bits 11 to 8
  localparam logic [3:0] OP_BIT_CLR = 4'h4;
  localparam logic [3:0] OP_BIT_SET = 4'h5;
  localparam logic [3:0] OP_TEST_CLR = 4'h6;
  localparam logic [3:0] OP_TEST_SET = 4'h7;
  // literal and control opcodes, bits 11 to 8; jump uses bits 11 to 9
  localparam logic [3:0] OP_RETURN = 4'h8;
  localparam logic [3:0] OP_CALL = 4'h9;
  localparam logic [2:0] OP_JUMP = 3'h5;
  localparam logic [3:0] OP_LOAD_LIT = 4'hc;
  localparam logic [3:0] OP_OR_LIT = 4'hd;
  localparam logic [3:0] OP_AND_LIT = 4'he;
  localparam logic [3:0] OP_XOR_LIT = 4'hf;
  // sequencer states
  typedef enum logic [2:0] {
    TBD_RUN = 3'b001,
    TBD_BUBBLE = 3'b010,
    TBD_STANDBY = 3'b100
  } tbd_state_t;
endpackage : tbd_pkg

// ---- verification/tbd_core_checker.sv ----
`timescale 1ns/1ps
module tbd_core_checker (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // watched outputs
  input wire logic [tbd_pkg::TBD_PC_W-1:0] progAddr,
  input wire logic [4:0] fileAddr,
  input wire logic fileWrEn,
  input wire logic [tbd_pkg::TBD_PORT_W-1:0] portDir,
  input wire logic [7:0] optionOut,
  input wire logic prescalerClr,
  input wire logic wdtClr,
  input wire logic standby
);
  import tbd_pkg::*;

  // one clock domain, so one default clock and reset
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // the pc may move only once in four clocks, even after a branch
  pc_spacing_a: assert property (
    $changed(progAddr) |=> $stable(progAddr) [*3])
    else $error("program counter moved twice in one instruction cycle");

  // at most one file write per instruction cycle
  wr_spacing_a: assert property (
    fileWrEn |=> !fileWrEn [*3])
    else $error("file write strobes closer than one instruction cycle");

  // pc low and status live inside the core, never on the file bus
  wr_target_a: assert property (
    fileWrEn |-> fileAddr != TBD_FA_PCL && fileAddr != TBD_FA_STATUS)
    else $error("file write strobe aimed at an internal address");

  // clear only on a timer write while the prescaler belongs to it
  presc_clr_a: assert property (
    prescalerClr == (fileWrEn && fileAddr == TBD_FA_TIMER &&
      !optionOut[TBD_OPT_PSA]))
    else $error("prescaler clear does not match a timer write");

  // watchdog clear is a lone pulse and writes no file
  wdt_pulse_a: assert property (
    wdtClr |-> !fileWrEn ##1 !wdtClr)
    else $error("watchdog clear longer than one clock or with a write");

  // nothing runs while the core stays in standby
  sleep_hold_a: assert property (
    standby ##1 standby |-> $stable(progAddr) && !fileWrEn)
    else $error("core advanced while in standby");

  // loading the option register touches no file register
  opt_nowrite_a: assert property (
    $changed(optionOut) |-> !fileWrEn ##1 !fileWrEn)
    else $error("option load came with a file write");

  // loading the direction latches touches no file register
  dir_nowrite_a: assert property (
    $changed(portDir) |-> !fileWrEn ##1 !fileWrEn)
    else $error("direction load came with a file write");

  // main scenarios reached
  cover property (prescalerClr);
  cover property ($rose(standby));
  cover property ($changed(portDir));
  cover property (fileWrEn);
endmodule : tbd_core_checker

bind tbd_core tbd_core_checker i_tbd_core_checker (
  .ref_clk, .reset, .progAddr, .fileAddr, .fileWrEn, .portDir,
  .optionOut, .prescalerClr, .wdtClr, .standby
);

// ---- verification/tbd_mem_model.sv ----
`timescale 1ns/1ps
module tbd_mem_model (
  // clock
  input wire logic ref_clk,
  // program memory side
  input wire logic [tbd_pkg::TBD_PC_W-1:0] progAddr,
  output logic [11:0] instrWord,
  // file memory side
  input wire logic [4:0] fileAddr,
  output logic [7:0] fileRdData,
  input wire logic fileWrEn,
  input wire logic [7:0] fileWrData
);
  import tbd_pkg::*;

  // contents are loaded by the bench before each run
  logic [11:0] progRom [0:511];
  logic [7:0] fileRam [0:31];

  // asynchronous reads, so the word is ready long before capture
  assign instrWord = progRom[progAddr];
  assign fileRdData = fileRam[fileAddr];

  // a write lands on the edge that sees the one-clock strobe
  always @(posedge ref_clk) begin
    if (fileWrEn === 1'b1) begin
      fileRam[fileAddr] <= fileWrData;
    end
  end
endmodule : tbd_mem_model

// ---- verification/twelve_bit_instruction_decoder_test.sv ----
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  totalChecks++; \
  if ((got) !== (exp)) begin \
    errTotal++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
  end \
end

module twelve_bit_instruction_decoder_test;
  import tbd_pkg::*;

  // design inputs, all given a value at time zero
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [5:0] portPins = 6'h00;
  logic wakeReq = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  // design outputs and memory wires
  logic [TBD_PC_W-1:0] progAddr;
  logic [11:0] instrWord;
  logic [4:0] fileAddr;
  logic [7:0] fileRdData, fileWrData, optionOut, regRdData;
  logic [5:0] portDir;
  logic fileWrEn, prescalerClr, wdtClr, standby;
  int errTotal = 0;
  int totalChecks = 0;
  int presCnt = 0;
  int wdtCnt = 0;

  tbd_core i_tbd_core (
    .ref_clk, .reset, .progAddr, .instrWord, .fileAddr, .fileRdData,
    .fileWrEn, .fileWrData, .portPins, .portDir, .optionOut,
    .prescalerClr, .wdtClr, .standby, .wakeReq, .regAddr, .regWrData,
    .regWr, .regRd, .regRdData
  );

  tbd_mem_model i_tbd_mem_model (
    .ref_clk, .progAddr, .instrWord, .fileAddr, .fileRdData, .fileWrEn,
    .fileWrData
  );

  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;

  // count prescaler and watchdog clears; pulses are one clock wide
  always @(posedge ref_clk) begin
    if (prescalerClr === 1'b1) presCnt++;
    if (wdtClr === 1'b1) wdtCnt++;
  end

  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  // hold reset five clocks with a clean rom of no-ops
  task automatic prep;
    reset <= 1'b1;
    presCnt = 0;
    wdtCnt = 0;
    for (int i = 0; i < 512; i++) i_tbd_mem_model.progRom[i] = 12'h000;
    repeat (5) @(posedge ref_clk);
  endtask : prep

  task automatic go(input int n);
    reset <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask : go

  task automatic prog(input int base, input logic [11:0] w[$]);
    foreach (w[i]) i_tbd_mem_model.progRom[base + i] = w[i];
  endtask : prog

  task automatic wrReg(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask : wrReg

  // read data stands only in the cycle after the strobe
  task automatic chkReg(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 d = regRdData;
    `CHK(d, e)
  endtask : chkReg

  // clocks the pc rests at address a; bounded so a stuck pc fails
  task automatic gap(input logic [8:0] a, input int e);
    int n = 0;
    while (progAddr !== a && n < 200) begin
      @(posedge ref_clk);
      #1 n++;
    end
    n = 0;
    while (progAddr === a && n < 200) begin
      @(posedge ref_clk);
      #1 n++;
    end
    `CHK(n, e)
  endtask : gap

  task automatic s_lit;
    prep();
    prog(0, {12'hc5a, 12'he0f, 12'hd30, 12'h028, 12'hf3a, 12'hc07,
      12'ha06});
    go(60);
    `CHK(i_tbd_mem_model.fileRam[8], 8'h3a)
    chkReg(TBD_REG_ACC, 8'h07);
    chkReg(TBD_REG_STATUS, 8'h1c);
    chkReg(TBD_REG_CTRL, TBD_CTRL_RST);
    chkReg(4'hf, 8'h00);
    wrReg(TBD_REG_ACC, 8'h55);
    chkReg(TBD_REG_ACC, 8'h07);
    // a control write must land; halting also freezes the phase counter
    wrReg(TBD_REG_CTRL, 8'h00);
    chkReg(TBD_REG_CTRL, 8'h00);
  endtask : s_lit

  task automatic s_byte;
    prep();
    i_tbd_mem_model.fileRam[9] = 8'h0f;
    i_tbd_mem_model.fileRam[10] = 8'hf0;
    i_tbd_mem_model.fileRam[11] = 8'h00;
    prog(0, {12'hc33, 12'h129, 12'h14a, 12'h1aa, 12'h209, 12'h22b,
      12'ha06});
    go(60);
    `CHK(i_tbd_mem_model.fileRam[9], 8'h3f)
    `CHK(i_tbd_mem_model.fileRam[10], 8'hc0)
    chkReg(TBD_REG_ACC, 8'h3f);
    chkReg(TBD_REG_STATUS, 8'h1c);
  endtask : s_byte

  task automatic s_rot;
    prep();
    i_tbd_mem_model.fileRam[12] = 8'h81;
    i_tbd_mem_model.fileRam[13] = 8'h80;
    prog(0, {12'h36c, 12'h30c, 12'h36d, 12'h022});
    prog(9'h081, {12'ha81});
    go(40);
    `CHK(i_tbd_mem_model.fileRam[12], 8'h02)
    `CHK(i_tbd_mem_model.fileRam[13], 8'h00)
    chkReg(TBD_REG_ACC, 8'h81);
    chkReg(TBD_REG_STATUS, 8'h19);
    // the accumulator written to pc low must have moved the pc there
    chkReg(TBD_REG_PCLO, 8'h81);
  endtask : s_rot

  task automatic s_skip;
    int ad[7] = '{2, 3, 4, 5, 7, 8, 10};
    int cy[7] = '{8, 4, 4, 4, 8, 4, 8};
    prep();
    i_tbd_mem_model.fileRam[13] = 8'h01;
    i_tbd_mem_model.fileRam[14] = 8'hff;
    prog(0, {12'h2ed, 12'hc11, 12'hc22, 12'h70d, 12'hc33, 12'h60d,
      12'hc44, 12'h5ed, 12'h3ce, 12'hc55, 12'h4ed, 12'ha0b});
    go(0);
    foreach (ad[i]) gap(9'(ad[i]), cy[i]);
    repeat (20) @(posedge ref_clk);
    `CHK(i_tbd_mem_model.fileRam[13], 8'h00)
    `CHK(i_tbd_mem_model.fileRam[14], 8'hff)
    chkReg(TBD_REG_ACC, 8'h00);
    chkReg(TBD_REG_STATUS, 8'h18);
  endtask : s_skip

  task automatic s_branch;
    prep();
    prog(0, {12'hb05});
    prog(9'h105, {12'h920, 12'h02f, 12'hb07});
    prog(9'h020, {12'h8a5});
    go(0);
    gap(9'h000, 4);
    gap(9'h105, 8);
    gap(9'h020, 8);
    gap(9'h106, 8);
    repeat (20) @(posedge ref_clk);
    `CHK(i_tbd_mem_model.fileRam[15], 8'ha5)
    chkReg(TBD_REG_PCLO, 8'h07);
    chkReg(TBD_REG_PCHI, 8'h01);
    chkReg(TBD_REG_STATUS, 8'h18);
  endtask : s_branch

  task automatic s_ctl;
    prep();
    prog(0, {12'hc35, 12'h002, 12'hc2a, 12'h006, 12'h007, 12'h001,
      12'h003, 12'hc99, 12'h004, 12'ha09});
    go(60);
    `CHK(optionOut, 8'h35)
    `CHK(portDir, 6'h2a)
    `CHK(standby, 1'b1)
    chkReg(TBD_REG_STATUS, 8'h10);
    `CHK(wdtCnt, 1)
    chkReg(TBD_REG_ACC, 8'h2a);
    // wake through the synchroniser, then let the core run on
    wakeReq <= 1'b1;
    repeat (40) @(posedge ref_clk);
    wakeReq <= 1'b0;
    `CHK(standby, 1'b0)
    chkReg(TBD_REG_ACC, 8'h99);
    // the watchdog clear after waking sets power-down back
    chkReg(TBD_REG_STATUS, 8'h18);
    `CHK(wdtCnt, 2)
  endtask : s_ctl

  task automatic s_port;
    prep();
    i_tbd_mem_model.fileRam[6] = 8'haa;
    portPins <= 6'h15;
    prog(0, {12'hc00, 12'h021, 12'h002, 12'h021, 12'h206, 12'h030,
      12'ha06});
    go(60);
    `CHK(i_tbd_mem_model.fileRam[16], 8'h15)
    `CHK(presCnt, 1)
    `CHK(optionOut, 8'h00)
  endtask : s_port

  // main sequence
  initial begin
    s_lit();
    s_byte();
    s_rot();
    s_skip();
    s_branch();
    s_ctl();
    s_port();
    end_of_test();
  end

  // the whole run needs well under 5 us; a hang is cut short here
  initial begin
    #20us;
    errTotal++;
    end_of_test();
  end
endmodule : twelve_bit_instruction_decoder_test
